// File: design/phy_basic_control_register.sv
// basic control register of a 10/100 transceiver, reached over mdc/mdio
// assumes mdc well below clk_i/4; negotiation engine shares clk_i
`timescale 1ns/10ps
module phy_basic_control_register (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 mdc_i,
  input  wire logic                 mdio_i,
  output logic                      mdio_o,
  output logic                      mdio_oe_o,
  input  wire phy_ctl_pkg::strap_t  strap_i,
  input  wire logic                 an_speed_100_i,
  input  wire logic                 an_full_duplex_i,
  output phy_ctl_pkg::mode_t        mode_o
);

  localparam int unsigned SW = $bits(phy_ctl_pkg::strap_t) + 2;

  phy_ctl_pkg::phy_state_t r;         // registered state
  phy_ctl_pkg::phy_state_t n;         // next state
  phy_ctl_pkg::strap_t     strap_s;   // synchronised straps
  logic                    mdc_s;     // synchronised mdc
  logic                    mdio_s;    // synchronised mdio
  logic [SW-1:0]           sync_q;    // synchroniser output
  logic                    mdc_rise;  // one cycle per mdc rising edge
  logic [12:0]             hdr;       // st bit, op, phy and reg address
  logic [15:0]             wdata;     // completed write data
  logic                    wr_commit; // write to basic control lands now
  logic [15:0]             img;       // read image of the addressed reg

  // all pins pass two flops first
  sync_stages #(
    .WIDTH (SW)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({strap_i, mdc_i, mdio_i}),
    .q_o   (sync_q)
  );

  assign strap_s  = sync_q[SW-1:2];
  assign mdc_s    = sync_q[1];
  assign mdio_s   = sync_q[0];

  // edge of the sampled management clock
  assign mdc_rise = mdc_s & ~r.mdc_q;

  // header and data with the newest bit shifted in
  assign hdr      = {r.shift[11:0], mdio_s};
  assign wdata    = {r.shift[14:0], mdio_s};

  // last data bit of a write to address zero
  assign wr_commit = mdc_rise && (r.state == phy_ctl_pkg::wr_s)
                     && (r.bit_cnt == phy_ctl_pkg::DATA_LAST)
                     && (r.reg_addr == phy_ctl_pkg::BASIC_CONTROL_ADDR);

  // read image: only address zero is populated here
  always_comb begin
    img = 16'h0000;
    if (r.reg_addr == phy_ctl_pkg::BASIC_CONTROL_ADDR) begin
      img[phy_ctl_pkg::LOOPBACK_BIT]   = r.ctl.loopback;
      img[phy_ctl_pkg::SPEED_BIT]      = r.ctl.speed;
      img[phy_ctl_pkg::AN_ENABLE_BIT]  = r.ctl.an_enable;
      img[phy_ctl_pkg::POWER_DOWN_BIT] = r.ctl.power_down;
      img[phy_ctl_pkg::ISOLATE_BIT]    = r.ctl.isolate;
      img[phy_ctl_pkg::DUPLEX_BIT]     = r.ctl.duplex;
      img[phy_ctl_pkg::COL_TEST_BIT]   = r.ctl.col_test;
    end
  end

  // next state: frame walker, register writes, strap reload
  always_comb begin
    n          = r;
    n.mdc_q    = mdc_s;
    n.soft_rst = 1'b0;
    n.an_rst   = 1'b0;

    // frame walker advances once per mdc rise
    if (mdc_rise) begin
      case (r.state)
        phy_ctl_pkg::idle_s: begin
          // count preamble ones, a zero after enough starts a frame
          if (mdio_s) begin
            if (r.pre_cnt != phy_ctl_pkg::PREAMBLE_LEN) begin
              n.pre_cnt = r.pre_cnt + 6'h01;
            end
          end else if (r.pre_cnt == phy_ctl_pkg::PREAMBLE_LEN) begin
            n.state   = phy_ctl_pkg::hdr_s;
            n.bit_cnt = 5'h00;
            n.shift   = 16'h0000;
            n.pre_cnt = 6'h00;
          end else begin
            n.pre_cnt = 6'h00;
          end
        end
        phy_ctl_pkg::hdr_s: begin
          // gather start bit, opcode and both addresses
          n.shift   = {r.shift[14:0], mdio_s};
          n.bit_cnt = r.bit_cnt + 5'h01;
          if (r.bit_cnt == phy_ctl_pkg::HDR_LAST) begin
            n.bit_cnt  = 5'h00;
            n.reg_addr = hdr[4:0];
            n.is_read  = (hdr[11:10] == phy_ctl_pkg::OP_READ);
            if (hdr[12] && (hdr[9:5] == strap_s.phy_addr_strap)
                && ((hdr[11:10] == phy_ctl_pkg::OP_READ)
                || (hdr[11:10] == phy_ctl_pkg::OP_WRITE))) begin
              n.state = phy_ctl_pkg::ta_s;
            end else begin
              n.state = phy_ctl_pkg::idle_s;
            end
          end
        end
        phy_ctl_pkg::ta_s: begin
          // turnaround: on reads drive the second bit low
          if (r.bit_cnt == 5'h00) begin
            n.bit_cnt = 5'h01;
            if (r.is_read) begin
              n.mdoe = 1'b1;
              n.mdo  = 1'b0;
            end
          end else begin
            n.bit_cnt = 5'h00;
            if (r.is_read) begin
              n.state = phy_ctl_pkg::rd_s;
              n.shift = img;
              n.mdo   = img[15];
            end else begin
              n.state = phy_ctl_pkg::wr_s;
            end
          end
        end
        phy_ctl_pkg::rd_s: begin
          // shift out msb first, release after bit 0
          if (r.bit_cnt == phy_ctl_pkg::DATA_LAST) begin
            n.state = phy_ctl_pkg::idle_s;
            n.mdoe  = 1'b0;
            n.mdo   = 1'b0;
          end else begin
            n.shift   = {r.shift[14:0], 1'b0};
            n.mdo     = r.shift[14];
            n.bit_cnt = r.bit_cnt + 5'h01;
          end
        end
        phy_ctl_pkg::wr_s: begin
          // shift in msb first; commit handled below
          n.shift   = wdata;
          n.bit_cnt = r.bit_cnt + 5'h01;
          if (r.bit_cnt == phy_ctl_pkg::DATA_LAST) begin
            n.state = phy_ctl_pkg::idle_s;
          end
        end
        default: begin
          n.state = phy_ctl_pkg::idle_s;
          n.mdoe  = 1'b0;
        end
      endcase
    end

    // strap reload after hardware or software reset
    if (r.load_cnt != 2'h0) begin
      n.load_cnt      = r.load_cnt - 2'h1;
      n.ctl.an_enable = strap_s.autoneg_enable_strap;
      n.ctl.isolate   = strap_s.isolate_strap;
      n.ctl.speed     = strap_s.speed_strap;
      n.ctl.duplex    = ~strap_s.duplex_strap;
    end

    // write to basic control
    if (wr_commit) begin
      if (r.ctl.power_down && wdata[phy_ctl_pkg::RESET_BIT]) begin
        n.ctl.power_down = 1'b0;
      end else if (wdata[phy_ctl_pkg::RESET_BIT]) begin
        // full reset: fixed bits clear, strap bits reload
        n.ctl.loopback   = 1'b0;
        n.ctl.power_down = 1'b0;
        n.ctl.col_test   = 1'b0;
        n.soft_rst       = 1'b1;
        n.load_cnt       = phy_ctl_pkg::STRAP_LOAD_CYCLES;
      end else begin
        n.ctl.loopback   = wdata[phy_ctl_pkg::LOOPBACK_BIT];
        n.ctl.speed      = wdata[phy_ctl_pkg::SPEED_BIT];
        n.ctl.an_enable  = wdata[phy_ctl_pkg::AN_ENABLE_BIT];
        n.ctl.power_down = wdata[phy_ctl_pkg::POWER_DOWN_BIT];
        n.ctl.isolate    = wdata[phy_ctl_pkg::ISOLATE_BIT];
        n.ctl.duplex     = wdata[phy_ctl_pkg::DUPLEX_BIT];
        n.ctl.col_test   = wdata[phy_ctl_pkg::COL_TEST_BIT];
        n.an_rst         = wdata[phy_ctl_pkg::AN_RESTART_BIT];
      end
    end

    // negotiated result wins while autoneg is on
    n.eff_speed  = r.ctl.an_enable ? an_speed_100_i : r.ctl.speed;
    n.eff_duplex = r.ctl.an_enable ? an_full_duplex_i : r.ctl.duplex;
  end

  // state register; reset reloads straps once released
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r          <= '0;
      r.load_cnt <= phy_ctl_pkg::STRAP_LOAD_CYCLES;
    end else begin
      r <= n;
    end
  end

  // pins and mode straight from flops
  assign mdio_o             = r.mdo;
  assign mdio_oe_o          = r.mdoe;
  assign mode_o.loopback    = r.ctl.loopback;
  assign mode_o.speed_100   = r.eff_speed;
  assign mode_o.an_enable   = r.ctl.an_enable;
  assign mode_o.power_down  = r.ctl.power_down;
  assign mode_o.isolate     = r.ctl.isolate;
  assign mode_o.full_duplex = r.eff_duplex;
  assign mode_o.col_test    = r.ctl.col_test;
  assign mode_o.an_restart  = r.an_rst;
  assign mode_o.soft_reset  = r.soft_rst;

  // checks on the block's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a plain reset write
  sequence rst_wr_seq;
    wr_commit && wdata[phy_ctl_pkg::RESET_BIT] && !r.ctl.power_down;
  endsequence

  // a reset write while powered down
  sequence wake_wr_seq;
    wr_commit && wdata[phy_ctl_pkg::RESET_BIT] && r.ctl.power_down;
  endsequence

  // plain write without reset
  sequence ctl_wr_seq;
    wr_commit && !wdata[phy_ctl_pkg::RESET_BIT];
  endsequence

  // a write frame to any other address ends, no strap reload pending
  sequence other_wr_seq;
    mdc_rise && (r.state == phy_ctl_pkg::wr_s) && (r.bit_cnt == phy_ctl_pkg::DATA_LAST)
    && (r.reg_addr != phy_ctl_pkg::BASIC_CONTROL_ADDR) && (r.load_cnt == 2'h0);
  endsequence

  // autoneg off for two cycles running
  sequence manual_seq;
    !r.ctl.an_enable ##1 !r.ctl.an_enable;
  endsequence

  soft_reset_pulse_a: assert property (
      rst_wr_seq |=> mode_o.soft_reset ##1 !mode_o.soft_reset)
    else $error("software reset not a single pulse after reset write");

  reset_relatch_a: assert property (
      rst_wr_seq |=> r.load_cnt == phy_ctl_pkg::STRAP_LOAD_CYCLES)
    else $error("software reset did not relatch straps");

  reset_clear_a: assert property (
      rst_wr_seq |=> !mode_o.loopback && !mode_o.power_down && !mode_o.col_test)
    else $error("software reset left fixed bits set");

  wake_only_a: assert property (wake_wr_seq |=> !r.ctl.power_down && !mode_o.soft_reset)
    else $error("first reset write in power-down did more than wake");

  loopback_wr_a: assert property (
      ctl_wr_seq |=> mode_o.loopback == $past(wdata[phy_ctl_pkg::LOOPBACK_BIT]))
    else $error("loopback bit did not follow write");

  speed_select_a: assert property (manual_seq |-> mode_o.speed_100 == $past(r.ctl.speed))
    else $error("manual speed not applied with autoneg off");

  an_override_a: assert property (
      r.ctl.an_enable |=> mode_o.full_duplex == $past(an_full_duplex_i)
      && mode_o.speed_100 == $past(an_speed_100_i))
    else $error("negotiated result did not override manual bits");

  isolate_wr_a: assert property (
      ctl_wr_seq |=> mode_o.isolate == $past(wdata[phy_ctl_pkg::ISOLATE_BIT]))
    else $error("isolate bit did not follow write");

  restart_pulse_a: assert property (
      mode_o.an_restart |-> $past(wr_commit) ##1 !mode_o.an_restart)
    else $error("autoneg restart not a single pulse from a write");

  duplex_default_a: assert property (
      r.load_cnt == 2'h1 |=> r.ctl.duplex == !$past(strap_s.duplex_strap))
    else $error("duplex default not inverse of strap");

  col_test_wr_a: assert property (
      ctl_wr_seq |=> mode_o.col_test == $past(wdata[phy_ctl_pkg::COL_TEST_BIT]))
    else $error("collision test bit did not follow write");

  strap_default_a: assert property (
      r.load_cnt == 2'h1 |=> r.ctl.an_enable == $past(strap_s.autoneg_enable_strap)
      && r.ctl.isolate == $past(strap_s.isolate_strap)
      && r.ctl.speed == $past(strap_s.speed_strap))
    else $error("strap defaults not loaded");

  reserved_zero_a: assert property (
      (r.state == phy_ctl_pkg::rd_s) && (r.reg_addr == phy_ctl_pkg::BASIC_CONTROL_ADDR)
      && (r.bit_cnt >= phy_ctl_pkg::RSV_FIRST_CNT) |-> mdio_oe_o && !mdio_o)
    else $error("reserved bits not read as zero");

  vendor_zero_a: assert property (
      (r.state == phy_ctl_pkg::rd_s) && (r.reg_addr >= phy_ctl_pkg::VENDOR_BASE_ADDR)
      |-> !mdio_o)
    else $error("vendor range read not zero");

  other_wr_a: assert property (other_wr_seq |=> r.ctl == $past(r.ctl))
    else $error("write to another address changed basic control");

  drive_read_a: assert property (
      mdio_oe_o |-> r.is_read
      && (r.state == phy_ctl_pkg::ta_s || r.state == phy_ctl_pkg::rd_s))
    else $error("mdio driven outside a read frame");

  turn_low_a: assert property (
      (r.state == phy_ctl_pkg::ta_s) && mdio_oe_o |-> !mdio_o)
    else $error("read turnaround not driven low");

endmodule

// File: shared/phy_ctl_pkg.sv
// constants, field layout and carrier types of the basic control register block
// assumes one 10 MHz core clock; management frames arrive on sampled mdc/mdio pins
//
// Operation
// - decode 32 addresses; vendor range reads zero
// - reset bit starts software reset, self-clears
// - loopback bit selects loopback mode, resets zero
// - speed bit picks 100/10, ignored under autoneg
// - autoneg enable; negotiated result overrides speed, duplex
// - in power-down, first reset write only wakes
// - following reset write resets and relatches straps
// - isolate bit cuts device from mac interface
// - restart bit restarts autoneg, self-clears, resets zero
// - duplex bit: full/half, default inverse duplex strap
// - collision test bit, resets zero
// - autoneg, isolate, speed defaults come from straps
package phy_ctl_pkg;

  // management register space
  localparam int unsigned NUM_REGS            = 32;
  localparam logic [4:0]  BASIC_CONTROL_ADDR  = 5'h00;
  localparam logic [4:0]  VENDOR_BASE_ADDR    = 5'h10;

  // basic control field positions
  localparam int unsigned RESET_BIT      = 15;
  localparam int unsigned LOOPBACK_BIT   = 14;
  localparam int unsigned SPEED_BIT      = 13;
  localparam int unsigned AN_ENABLE_BIT  = 12;
  localparam int unsigned POWER_DOWN_BIT = 11;
  localparam int unsigned ISOLATE_BIT    = 10;
  localparam int unsigned AN_RESTART_BIT = 9;
  localparam int unsigned DUPLEX_BIT     = 8;
  localparam int unsigned COL_TEST_BIT   = 7;
  localparam int unsigned RSV_MSB        = 6;

  // frame layout and counts
  localparam logic [5:0]  PREAMBLE_LEN   = 6'h20;
  localparam logic [4:0]  HDR_LAST       = 5'h0c;
  localparam logic [4:0]  DATA_LAST      = 5'h0f;
  localparam logic [4:0]  RSV_FIRST_CNT  = 5'h09;
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [1:0]  OP_WRITE       = 2'h1;

  // cycles the strap values are reloaded after any reset
  localparam logic [1:0]  STRAP_LOAD_CYCLES = 2'h3;
  localparam int unsigned SYNC_STAGES       = 2;

  // sampled strapping pins
  typedef struct packed {
    logic       autoneg_enable_strap;
    logic       isolate_strap;
    logic       speed_strap;
    logic       duplex_strap;
    logic [4:0] phy_addr_strap;
  } strap_t;

  // stored control bits
  typedef struct packed {
    logic loopback;
    logic speed;
    logic an_enable;
    logic power_down;
    logic isolate;
    logic duplex;
    logic col_test;
  } ctl_bits_t;

  // mode seen by the rest of the transceiver
  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic an_enable;
    logic power_down;
    logic isolate;
    logic full_duplex;
    logic col_test;
    logic an_restart;
    logic soft_reset;
  } mode_t;

  // management frame walker states
  typedef enum logic [2:0] {
    idle_s,
    hdr_s,
    ta_s,
    rd_s,
    wr_s
  } mdio_state_t;

  // whole state of the control block
  typedef struct packed {
    mdio_state_t state;
    logic [5:0]  pre_cnt;
    logic [4:0]  bit_cnt;
    logic [15:0] shift;
    logic        is_read;
    logic [4:0]  reg_addr;
    logic        mdo;
    logic        mdoe;
    logic        mdc_q;
    ctl_bits_t   ctl;
    logic        eff_speed;
    logic        eff_duplex;
    logic [1:0]  load_cnt;
    logic        soft_rst;
    logic        an_rst;
  } phy_state_t;

endpackage

// File: design/sync_stages.sv
// two flip-flop synchroniser for a bundle of pin inputs
// assumes the inputs are quasi-static or slow against clk_i
`timescale 1ns/10ps
module sync_stages #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  // first stage, read only by the second
  logic [WIDTH-1:0] meta_r;

  // two stages, cleared by reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule

// File: tb/mgmt_station.sv
// station management controller model: sends clause 22 frames on mdc/mdio
// assumes mdio_i is the resolved wire level, pulled up when nobody drives
`timescale 1ns/10ps
module mgmt_station (
  input  wire logic clk_i,
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  // mdc stands low between frames, station line released
  initial begin
    mdc_o     = 1'b0;
    mdio_o    = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // one mdc period: data set while low, sampled at the rise, 6 clk low and 5 clk high
  task automatic put_bit(input logic b, input logic drive, output logic smp);
    @(negedge clk_i);
    mdio_oe_o = drive;
    mdio_o    = b;
    repeat (5) @(negedge clk_i);
    smp   = mdio_i;
    mdc_o = 1'b1;
    repeat (5) @(negedge clk_i);
    mdc_o = 1'b0;
  endtask

  // whole frame: preamble, start, op, phy, reg, turnaround, 16 data bits msb first
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rdat);
    logic [63:0] w;
    logic        s;
    w = {32'hffff_ffff, 2'b01, (rd ? 2'b10 : 2'b01), phy, ra, 2'b10, wd};
    for (int i = 63; i >= 0; i--) begin
      put_bit(w[i], !(rd && i < 18), s);
      if (i < 16) begin
        rdat[i] = s;
      end
    end
    mdio_oe_o = 1'b0;
  endtask
endmodule

// File: tb/phy_basic_control_register_test.sv
// self-checking bench of the basic control register behind mdc/mdio
// assumes the design samples mdc/mdio through synchronisers and reacts within 4 clk
`timescale 1ns/10ps
module phy_basic_control_register_test;
  localparam logic [4:0] PHY = 5'h03;       // strapped station address
  logic                 clk_i;              // core clock
  logic                 rst_i;              // async reset
  logic                 mdc, m_mdio, m_oe;  // station side
  logic                 d_mdio, d_oe;       // device side
  wire                  mdio_w;             // resolved wire
  phy_ctl_pkg::strap_t  strap;              // strap pins
  logic                 an_sp, an_fd;       // negotiated result
  phy_ctl_pkg::mode_t   mode;               // device mode
  logic                 rst_seen, an_seen, oe_seen; // sticky pulse flags
  int                   miscompares, n_compared;
  logic [15:0]          rdat;               // last read word

  // pull-up when neither side drives
  assign mdio_w = d_oe ? d_mdio : (m_oe ? m_mdio : 1'b1);

  always #50 clk_i = ~clk_i;

  // catch one-cycle pulses and any device drive, away from the launching edge
  always @(negedge clk_i) begin
    if (mode.soft_reset) rst_seen <= 1'b1;
    if (mode.an_restart) an_seen <= 1'b1;
    if (d_oe) oe_seen <= 1'b1;
  end

  phy_basic_control_register dut (
    .clk_i(clk_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(d_mdio),
    .mdio_oe_o(d_oe), .strap_i(strap), .an_speed_100_i(an_sp),
    .an_full_duplex_i(an_fd), .mode_o(mode)
  );

  mgmt_station station (
    .clk_i(clk_i), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(m_mdio), .mdio_oe_o(m_oe)
  );

  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // expected mode outputs from a register value
  function automatic logic [15:0] mode_of(input logic [15:0] r);
    return {7'h00, r[14], (r[12] ? an_sp : r[13]), r[12], r[11], r[10],
            (r[12] ? an_fd : r[8]), r[7], 2'b00};
  endfunction

  task automatic chk_mode(input logic [15:0] r);
    check("mode", {7'h00, mode}, mode_of(r));
  endtask

  task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] dummy;
    station.frame(1'b0, phy, ra, d, dummy);
    repeat (8) @(negedge clk_i);
  endtask

  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    station.frame(1'b1, PHY, ra, 16'h0000, rdat);
    repeat (8) @(negedge clk_i);
    check("read", rdat, exp);
  endtask

  // defaults taken from straps
  task automatic t_defaults;
    chk_mode(16'h2500);
    rd_chk(5'h00, 16'h2500);
    $display("test defaults done");
  endtask

  // plain fields, reserved bits dropped
  task automatic t_fields;
    wr(PHY, 5'h00, 16'h40ff);
    chk_mode(16'h4080);
    rd_chk(5'h00, 16'h4080);
    wr(PHY, 5'h00, 16'h0400);
    chk_mode(16'h0400);
    $display("test fields done");
  endtask

  // negotiated result overrides, restart self-clears
  task automatic t_autoneg;
    an_sp   = 1'b1;
    an_fd   = 1'b1;
    an_seen = 1'b0;
    wr(PHY, 5'h00, 16'h1200);
    check("restart pulse", {15'h0000, an_seen}, 16'h0001);
    chk_mode(16'h1000);
    rd_chk(5'h00, 16'h1000);
    $display("test autoneg done");
  endtask

  // first reset write in power-down only wakes, second resets and relatches straps
  task automatic t_power;
    wr(PHY, 5'h00, 16'h0880);
    chk_mode(16'h0880);
    rst_seen = 1'b0;
    wr(PHY, 5'h00, 16'h8000);
    check("no reset", {15'h0000, rst_seen}, 16'h0000);
    rd_chk(5'h00, 16'h0080);
    strap = {1'b1, 1'b0, 1'b1, 1'b1, PHY};
    wr(PHY, 5'h00, 16'h8000);
    check("reset pulse", {15'h0000, rst_seen}, 16'h0001);
    chk_mode(16'h3000);
    rd_chk(5'h00, 16'h3000);
    $display("test power done");
  endtask

  // other addresses and foreign station addresses
  task automatic t_space;
    rd_chk(5'h01, 16'h0000);
    wr(PHY, 5'h10, 16'hffff);
    rd_chk(5'h10, 16'h0000);
    oe_seen = 1'b0;
    station.frame(1'b1, 5'h04, 5'h00, 16'h0000, rdat);
    check("foreign drive", {15'h0000, oe_seen}, 16'h0000);
    wr(5'h04, 5'h00, 16'h4000);
    rd_chk(5'h00, 16'h3000);
    $display("test space done");
  endtask

  // mid-run hardware reset: fixed bits clear, other straps relatch
  task automatic t_hw_reset;
    strap = {1'b1, 1'b1, 1'b0, 1'b1, PHY};
    rst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check("reset mode", {7'h00, mode}, 16'h0000);
    rst_i = 1'b0;
    repeat (6) @(negedge clk_i);
    chk_mode(16'h1400);
    rd_chk(5'h00, 16'h1400);
    $display("test hw reset done");
  endtask

  task automatic results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    clk_i       = 1'b0;
    rst_i       = 1'b1;
    strap       = {1'b0, 1'b1, 1'b1, 1'b0, PHY};
    an_sp       = 1'b0;
    an_fd       = 1'b0;
    rst_seen    = 1'b0;
    an_seen     = 1'b0;
    oe_seen     = 1'b0;
    miscompares = 0;
    n_compared  = 0;
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (6) @(negedge clk_i);
    t_defaults();
    t_fields();
    t_autoneg();
    t_power();
    t_space();
    t_hw_reset();
    results();
  end

  // hang guard: about 20 frames of 704 clk each fit well inside
  initial begin
    #3000000;
    miscompares++;
    results();
  end
endmodule
